// file: design/dtsc_pkg.sv
// Package: constants and types of the dual timer shared control block
package dtsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned DTSC_AW = 4;
  localparam logic [1:0] DTSC_CTRL_IDX = 2'h1;
  localparam logic [DTSC_AW-1:0] DTSC_CTRL_ADDR = {DTSC_CTRL_IDX, 2'h0};
  localparam int unsigned DTSC_MODE_BIT = 7;
  localparam int unsigned DTSC_PINSEL_BIT = 6;
  localparam int unsigned DTSC_LOGIC_LSB = 4;
  localparam int unsigned DTSC_PP_LSB = 2;
  localparam int unsigned DTSC_SHORT_BIT = 1;
  localparam int unsigned DTSC_LONG_BIT = 0;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTSC_LOG_AND = 2'h0,
    DTSC_LOG_OR = 2'h1,
    DTSC_LOG_NOR = 2'h2,
    DTSC_LOG_NAND = 2'h3
  } dtsc_logic_e;

  typedef enum logic [1:0] {
    DTSC_EDGE_FALL = 2'h0,
    DTSC_EDGE_RISE = 2'h1,
    DTSC_EDGE_BOTH = 2'h2,
    DTSC_EDGE_RSVD = 2'h3
  } dtsc_edge_e;

  typedef enum logic [1:0] {
    DTSC_PP_NORMAL = 2'h0,
    DTSC_PP_PINGPONG = 2'h1,
    DTSC_PP_FORCE_LO = 2'h2,
    DTSC_PP_FORCE_HI = 2'h3
  } dtsc_pp_e;

  localparam logic [1:0] DTSC_FILT_NONE = 2'h0;
  localparam logic [1:0] DTSC_FILT_SHORT = 2'h1;
  localparam logic [1:0] DTSC_FILT_LONG = 2'h2;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int unsigned DTSC_FILT_SHORT_CYC = 4;
  localparam int unsigned DTSC_FILT_LONG_CYC = 8;
  localparam int unsigned DTSC_SCLK_DIV = 2;
  localparam logic [1:0] DTSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DTSC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic demod;
    logic pin_sel;
    logic [1:0] logic_sel;
    logic [1:0] pp_sel;
    logic short_init;
    logic long_init;
  } dtsc_ctrl_s;

  localparam dtsc_ctrl_s DTSC_CTRL_RST = '0;

  // Control bundle handed to the two counter/timers
  typedef struct packed {
    logic demod;
    logic pingpong;
    logic short_init;
    logic long_init;
    logic capture_rise;
    logic capture_fall;
  } dtsc_tmr_ctl_s;

endpackage

// file: design/dtsc_sclk_div.sv
// Divider producing the one-cycle SCLK enable from mclk
`timescale 1ns/1ps
`default_nettype none
module dtsc_sclk_div #(
  parameter int unsigned DIV = dtsc_pkg::DTSC_SCLK_DIV
) (
  input wire logic mclk,
  input wire logic rstn,
  output logic sclk_en
);
  import dtsc_pkg::*;

  logic [7:0] cnt_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      sclk_en <= 1'b0;
    end else if (cnt_q == 8'(DIV - 1)) begin
      cnt_q <= 8'h00;
      sclk_en <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      sclk_en <= 1'b0;
    end
  end

endmodule // dtsc_sclk_div
`default_nettype wire

// file: design/dtsc_glitch_filter.sv
// Glitch filter on the synchronised demodulator input
`timescale 1ns/1ps
`default_nettype none
module dtsc_glitch_filter (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sclk_en,
  input wire logic [1:0] filt_sel,
  input wire logic din,
  output logic level_q
);
  import dtsc_pkg::*;

  logic [3:0] cnt_q;
  logic [3:0] need;

  always_comb begin
    need = 4'h0;
    case (filt_sel)
      DTSC_FILT_SHORT: need = 4'(DTSC_FILT_SHORT_CYC);
      DTSC_FILT_LONG: need = 4'(DTSC_FILT_LONG_CYC);
      default: need = 4'h0;
    endcase
  end

  // A change is taken only after it has held for the chosen SCLK count
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      level_q <= 1'b0;
    end else if (need == 4'h0 || din == level_q) begin
      cnt_q <= 4'h0;
      level_q <= din; // [R08]
    end else if (sclk_en) begin
      if (cnt_q + 4'h1 >= need) begin
        cnt_q <= 4'h0;
        level_q <= din; // [R08]
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

endmodule // dtsc_glitch_filter
`default_nettype wire

// file: design/dtsc_top.sv
// Shared control register and output/input routing for two counter/timers
//
// Functional notes
// R01 - Mode bit: 0 transmit, 1 demodulation
// R02 - Transmit: pin select routes combined output
// R03 - Demodulation: pin select picks input pin
// R04 - Transmit: AND, OR, NOR, NAND combine
// R05 - Logic field survives stop-mode recovery
// R06 - Demodulation: falling, rising, both edge select
// R07 - Transmit: normal, ping-pong, force low/high
// R08 - Demodulation: no, 4 or 8 filter
// R09 - Transmit: short timer initial output level
// R10 - Transmit: long timer initial output level
// R11 - Rising edge flag, write one clears
// R12 - Falling edge flag, write one clears
// R13 - Software stops timers before ping-pong
`timescale 1ns/1ps
`default_nettype none
module dtsc_top #(
  parameter int unsigned SCLK_DIV = dtsc_pkg::DTSC_SCLK_DIV
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic stop_recover,
  // AXI4-Lite slave
  input wire logic [dtsc_pkg::DTSC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dtsc_pkg::DTSC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer side
  input wire logic short_timer_output,
  input wire logic long_timer_output,
  output dtsc_pkg::dtsc_tmr_ctl_s timer_ctl,
  // Port logic and pins
  input wire logic port_out_data,
  input wire logic port_out_oe_n,
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe_n,
  input wire logic timer_output_pin_i,
  input wire logic primary_demod_input_pin,
  input wire logic alternate_demod_input_pin
);
  import dtsc_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [DTSC_AW-1:0] a);
    addr_hit = (a == DTSC_CTRL_ADDR);
  endfunction

  function automatic logic combine(input logic [1:0] sel, input logic a, input logic b);
    case (sel)
      DTSC_LOG_AND: combine = a & b;
      DTSC_LOG_OR: combine = a | b;
      DTSC_LOG_NOR: combine = ~(a | b);
      DTSC_LOG_NAND: combine = ~(a & b);
      default: combine = a & b;
    endcase
  endfunction

  typedef enum logic [1:0] {
    DTSC_WR_IDLE = 2'h0,
    DTSC_WR_RESP = 2'h1
  } dtsc_wr_e;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  dtsc_ctrl_s ctrl_q;
  logic rise_flag_q;
  logic fall_flag_q;
  dtsc_wr_e wr_state_q;
  logic aw_got_q;
  logic w_got_q;
  logic [DTSC_AW-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic wr_fire;
  logic wr_hit;
  logic [7:0] ctrl_rd;
  logic sclk_en;
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic demod_in;
  logic filt_level;
  logic filt_prev_q;
  logic edge_rise;
  logic edge_fall;
  logic long_eff;
  logic combined;
  logic route_out;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_got_q && (wr_state_q == DTSC_WR_IDLE);
  assign s_axi_wready = !w_got_q && (wr_state_q == DTSC_WR_IDLE);
  assign wr_fire = (wr_state_q == DTSC_WR_IDLE)
                && (aw_got_q || s_axi_awvalid) && (w_got_q || s_axi_wvalid);
  assign wr_hit = addr_hit(aw_got_q ? awaddr_q : s_axi_awaddr);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      w_got_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      wbyte_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
    end
  end

  // Write data and lane seen at the write edge, held or live
  logic [7:0] wr_byte;
  logic wr_lane;
  assign wr_byte = w_got_q ? wbyte_q : s_axi_wdata[7:0];
  assign wr_lane = w_got_q ? wlane_q : s_axi_wstrb[0];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_state_q <= DTSC_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DTSC_RESP_OKAY;
    end else begin
      case (wr_state_q)
        DTSC_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= DTSC_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? DTSC_RESP_OKAY : DTSC_RESP_SLVERR;
          end
        end
        DTSC_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= DTSC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= DTSC_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  logic reg_wr;
  assign reg_wr = wr_fire && wr_hit && wr_lane;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Stop-mode recovery restores defaults except the combine field.
  // Bits 1:0 hold the initial levels only while in transmit mode;
  // in demodulation mode the same bits are the write-one-clear flags.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= DTSC_CTRL_RST; // [R01] [R05]
    end else if (stop_recover) begin
      ctrl_q.demod <= DTSC_CTRL_RST.demod;
      ctrl_q.pin_sel <= DTSC_CTRL_RST.pin_sel;
      ctrl_q.pp_sel <= DTSC_CTRL_RST.pp_sel;
      ctrl_q.short_init <= DTSC_CTRL_RST.short_init;
      ctrl_q.long_init <= DTSC_CTRL_RST.long_init; // [R05]
    end else if (reg_wr) begin
      ctrl_q.demod <= wr_byte[DTSC_MODE_BIT]; // [R01]
      ctrl_q.pin_sel <= wr_byte[DTSC_PINSEL_BIT];
      ctrl_q.logic_sel <= wr_byte[DTSC_LOGIC_LSB +: 2];
      ctrl_q.pp_sel <= wr_byte[DTSC_PP_LSB +: 2];
      if (!ctrl_q.demod) begin
        ctrl_q.short_init <= wr_byte[DTSC_SHORT_BIT]; // [R09]
        ctrl_q.long_init <= wr_byte[DTSC_LONG_BIT]; // [R10]
      end
    end
  end

  // ----------------------------------------------------------------
  // Edge flags
  // ----------------------------------------------------------------
  // A detected edge in the clearing cycle wins over the clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rise_flag_q <= 1'b0;
    end else if (ctrl_q.demod && edge_rise) begin
      rise_flag_q <= 1'b1; // [R11]
    end else if (stop_recover) begin
      rise_flag_q <= 1'b0;
    end else if (reg_wr && ctrl_q.demod && wr_byte[DTSC_SHORT_BIT]) begin
      rise_flag_q <= 1'b0; // [R11]
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fall_flag_q <= 1'b0;
    end else if (ctrl_q.demod && edge_fall) begin
      fall_flag_q <= 1'b1; // [R12]
    end else if (stop_recover) begin
      fall_flag_q <= 1'b0;
    end else if (reg_wr && ctrl_q.demod && wr_byte[DTSC_LONG_BIT]) begin
      fall_flag_q <= 1'b0; // [R12]
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_rd = {ctrl_q.demod, ctrl_q.pin_sel, ctrl_q.logic_sel, ctrl_q.pp_sel, 2'h0};
    if (ctrl_q.demod) begin
      ctrl_rd[DTSC_SHORT_BIT] = rise_flag_q; // [R11]
      ctrl_rd[DTSC_LONG_BIT] = fall_flag_q; // [R12]
    end else begin
      ctrl_rd[DTSC_SHORT_BIT] = ctrl_q.short_init;
      ctrl_rd[DTSC_LONG_BIT] = ctrl_q.long_init;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= DTSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (addr_hit(s_axi_araddr)) begin
        s_axi_rdata <= {24'h000000, ctrl_rd};
        s_axi_rresp <= DTSC_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= DTSC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Demodulator input path
  // ----------------------------------------------------------------
  dtsc_sclk_div #(
    .DIV(SCLK_DIV)
  ) u_sclk_div (
    .mclk(mclk),
    .rstn(rstn),
    .sclk_en(sclk_en)
  );

  // Both candidate pins are synchronised so a select change never
  // exposes a metastable stage to the filter.
  logic [1:0] pin_raw;
  assign pin_raw = {alternate_demod_input_pin, primary_demod_input_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pin_meta_q[gi] <= 1'b0;
          pin_sync_q[gi] <= 1'b0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  assign demod_in = ctrl_q.pin_sel ? pin_sync_q[1] : pin_sync_q[0]; // [R03]

  dtsc_glitch_filter u_filter (
    .mclk(mclk),
    .rstn(rstn),
    .sclk_en(sclk_en),
    .filt_sel(ctrl_q.demod ? ctrl_q.pp_sel : DTSC_FILT_NONE),
    .din(demod_in),
    .level_q(filt_level)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      filt_prev_q <= 1'b0;
    end else begin
      filt_prev_q <= filt_level;
    end
  end

  assign edge_rise = filt_level && !filt_prev_q;
  assign edge_fall = !filt_level && filt_prev_q;

  // Reserved edge code captures nothing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_ctl.capture_rise <= 1'b0;
      timer_ctl.capture_fall <= 1'b0;
    end else begin
      timer_ctl.capture_rise <= ctrl_q.demod && edge_rise
        && (ctrl_q.logic_sel == DTSC_EDGE_RISE || ctrl_q.logic_sel == DTSC_EDGE_BOTH); // [R06]
      timer_ctl.capture_fall <= ctrl_q.demod && edge_fall
        && (ctrl_q.logic_sel == DTSC_EDGE_FALL || ctrl_q.logic_sel == DTSC_EDGE_BOTH); // [R06]
    end
  end

  // ----------------------------------------------------------------
  // Transmit output path
  // ----------------------------------------------------------------
  always_comb begin
    case (ctrl_q.pp_sel)
      DTSC_PP_FORCE_LO: long_eff = 1'b0; // [R07]
      DTSC_PP_FORCE_HI: long_eff = 1'b1; // [R07]
      default: long_eff = long_timer_output;
    endcase
  end

  assign combined = combine(ctrl_q.logic_sel, short_timer_output, long_eff); // [R04]
  assign route_out = !ctrl_q.demod && ctrl_q.pin_sel;

  // Demodulation mode hands the pin back to the port logic
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_output_pin_o <= 1'b0;
      timer_output_pin_oe_n <= 1'b1;
    end else if (route_out) begin
      timer_output_pin_o <= combined; // [R02]
      timer_output_pin_oe_n <= 1'b0; // [R02]
    end else begin
      timer_output_pin_o <= port_out_data;
      timer_output_pin_oe_n <= port_out_oe_n;
    end
  end

  // Ping-pong is only flagged; start order is left to software
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_ctl.demod <= 1'b0;
      timer_ctl.pingpong <= 1'b0;
      timer_ctl.short_init <= 1'b0;
      timer_ctl.long_init <= 1'b0;
    end else begin
      timer_ctl.demod <= ctrl_q.demod; // [R01]
      timer_ctl.pingpong <= !ctrl_q.demod && ctrl_q.pp_sel == DTSC_PP_PINGPONG; // [R07] [R13]
      timer_ctl.short_init <= ctrl_q.short_init; // [R09]
      timer_ctl.long_init <= ctrl_q.long_init; // [R10]
    end
  end

  // Pin readback is not used inside this block
  logic unused_pin;
  assign unused_pin = timer_output_pin_i ^ (|s_axi_wdata[31:8]) ^ (|s_axi_wstrb[3:1]);

endmodule // dtsc_top
`default_nettype wire

// file: verif/dtsc_top_asserts.sv
// Concurrent checks on the ports of the shared timer control block
`timescale 1ns/1ps
`default_nettype none
module dtsc_top_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic stop_recover,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dtsc_pkg::DTSC_AW-1:0] s_axi_awaddr,
  input wire logic [dtsc_pkg::DTSC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dtsc_pkg::dtsc_tmr_ctl_s timer_ctl,
  input wire logic port_out_data,
  input wire logic port_out_oe_n,
  input wire logic timer_output_pin_o,
  input wire logic timer_output_pin_oe_n
);
  import dtsc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  sequence s_wr_go;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_go;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_LAT: assert property (s_wr_go |=> s_axi_bvalid && s_axi_bresp ==
    ($past(s_axi_awaddr) == DTSC_CTRL_ADDR ? DTSC_RESP_OKAY : DTSC_RESP_SLVERR))
    else $error("write answer wrong or late");
  AST_RD_LAT: assert property (s_rd_go |=> s_axi_rvalid && ($past(s_axi_araddr) == DTSC_CTRL_ADDR ||
    (s_axi_rresp == DTSC_RESP_SLVERR && s_axi_rdata == 32'h00000000)))
    else $error("read answer wrong or late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // ----------------------------------------------------------------
  // Mode, routing and recovery
  // ----------------------------------------------------------------
  AST_DEMOD_PORT: assert property (timer_ctl.demod |-> timer_output_pin_o == $past(port_out_data) &&
    timer_output_pin_oe_n == $past(port_out_oe_n))
    else $error("pin not left to port logic in demodulation");
  AST_PP_TX: assert property (timer_ctl.pingpong |-> !timer_ctl.demod)
    else $error("ping-pong flagged in demodulation");
  AST_CAP_DEMOD: assert property (timer_ctl.capture_rise || timer_ctl.capture_fall |->
    timer_ctl.demod || $past(timer_ctl.demod))
    else $error("capture pulse outside demodulation");
  AST_STOP: assert property (stop_recover |-> ##2 !timer_ctl.demod && !timer_ctl.pingpong)
    else $error("mode kept through stop recovery");
endmodule // dtsc_top_chk
bind dtsc_top dtsc_top_chk dtsc_top_chk_i (.mclk, .rstn, .stop_recover, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_awaddr, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_ctl,
  .port_out_data, .port_out_oe_n, .timer_output_pin_o, .timer_output_pin_oe_n);
`default_nettype wire

// file: verif/dtsc_pin_model.sv
// Model of the board pins around the timer output and demodulator inputs
`timescale 1ns/1ps
`default_nettype none
module dtsc_pin_model (
  input wire logic mclk,
  input wire logic src,
  input wire logic lvl,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic primary_pin,
  output logic alternate_pin,
  output logic pin_wire
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  logic idle_q = 1'b0;
  // Pull-up holds the shared pin when nobody drives it
  assign pin_wire = pin_oe_n ? 1'b1 : pin_o;
  // Unused source keeps moving so a wrong input mux cannot hide
  always @(posedge mclk) idle_q <= ~idle_q;
  assign primary_pin = src ? idle_q : lvl;
  assign alternate_pin = src ? lvl : idle_q;
endmodule // dtsc_pin_model
`default_nettype wire

// file: verif/dual_timer_shared_control_tb.sv
// Self-checking bench for the dual timer shared control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module dual_timer_shared_control_tb;
  import dtsc_pkg::*;
  logic mclk, rstn, stop_recover, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, short_timer_output;
  logic long_timer_output, port_out_data, port_out_oe_n, timer_output_pin_o, timer_output_pin_oe_n;
  logic timer_output_pin_i, primary_demod_input_pin, alternate_demod_input_pin, src, lvl;
  logic [DTSC_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  dtsc_tmr_ctl_s timer_ctl;
  int err_total = 0, check_count = 0, nrise = 0, nfall = 0;

  dtsc_top dtsc_top_i (.mclk, .rstn, .stop_recover, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .short_timer_output, .long_timer_output, .timer_ctl, .port_out_data, .port_out_oe_n, .timer_output_pin_o,
    .timer_output_pin_oe_n, .timer_output_pin_i, .primary_demod_input_pin, .alternate_demod_input_pin);
  dtsc_pin_model dtsc_pin_model_i (.mclk, .src, .lvl, .pin_o(timer_output_pin_o),
    .pin_oe_n(timer_output_pin_oe_n), .primary_pin(primary_demod_input_pin),
    .alternate_pin(alternate_demod_input_pin), .pin_wire(timer_output_pin_i));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (timer_ctl.capture_rise) nrise++;
    if (timer_ctl.capture_fall) nfall++;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [DTSC_AW-1:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [2:0] got;
    got = 3'b000;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (got != 3'b111) begin
      @(posedge mclk);
      // Late bready lets the response be seen waiting
      if (got == 3'b011 && !s_axi_bready) s_axi_bready <= 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
        got[0] = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        got[1] = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bready && s_axi_bvalid) begin
        got[2] = 1'b1;
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
      end
    end
  endtask
  task automatic rd(input logic [DTSC_AW-1:0] a, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    `CHK(s_axi_rresp, er)
  endtask
  task automatic wc(input logic [7:0] d);
    wr(DTSC_CTRL_ADDR, d, DTSC_RESP_OKAY);
  endtask
  task automatic rck(input logic [7:0] e);
    rd(DTSC_CTRL_ADDR, DTSC_RESP_OKAY);
    `CHK(rv, {24'h000000, e})
  endtask
  task automatic results();
    $display("Mismatches %0d, checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rck(8'h00);
    `CHK(timer_ctl, 6'h00)
    rd(4'h8, DTSC_RESP_SLVERR);
    `CHK(rv, 32'h00000000)
    wr(4'hC, 8'hFF, DTSC_RESP_SLVERR);
    rck(8'h00);
  endtask
  task automatic t_tx();
    logic le, ex;
    port_out_data <= 1'b1;
    port_out_oe_n <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK({timer_output_pin_o, timer_output_pin_oe_n, timer_output_pin_i}, 3'h5)
    port_out_oe_n <= 1'b1;
    for (int k = 0; k < 64; k++) begin
      short_timer_output <= k[0];
      long_timer_output <= k[1];
      wc({2'b01, k[3:2], k[5:4], 2'b00});
      repeat (2) @(posedge mclk);
      // Force codes override the long timer before the combine
      le = k[5] ? k[4] : k[1];
      ex = k[3] ^ ((k[3] ^ k[2]) ? (k[0] | le) : (k[0] & le));
      `CHK({timer_output_pin_o, timer_output_pin_oe_n}, {ex, 1'b0})
      `CHK(timer_ctl.pingpong, k[5:4] == 2'b01)
    end
    wc(8'h02);
    @(posedge mclk);
    `CHK({timer_ctl.short_init, timer_ctl.long_init}, 2'b10)
    wc(8'h01);
    @(posedge mclk);
    `CHK({timer_ctl.short_init, timer_ctl.long_init}, 2'b01)
  endtask
  task automatic t_demod();
    logic [7:0] cfg;
    for (int e = 0; e < 4; e++) begin
      cfg = {1'b1, e[0], e[1:0], 4'h0};
      wc(cfg | 8'h03);
      src <= e[0];
      // Source switch makes stray edges; clear them after settling
      repeat (10) @(posedge mclk);
      wc(cfg | 8'h03);
      nrise = 0;
      nfall = 0;
      lvl <= 1'b1;
      repeat (12) @(posedge mclk);
      rck(cfg | 8'h02);
      wc(cfg | 8'h01);
      rck(cfg | 8'h02);
      lvl <= 1'b0;
      repeat (12) @(posedge mclk);
      rck(cfg | 8'h03);
      wc(cfg | 8'h02);
      rck(cfg | 8'h01);
      wc(cfg | 8'h01);
      rck(cfg);
      `CHK(nrise, int'(e == 1 || e == 2))
      `CHK(nfall, int'(e == 0 || e == 2))
    end
  endtask
  task automatic t_filter();
    logic [7:0] cfg;
    for (int f = 1; f < 3; f++) begin
      cfg = {4'h8, f[1:0], 2'b00};
      src <= 1'b0;
      wc(cfg | 8'h03);
      repeat (30) @(posedge mclk);
      wc(cfg | 8'h03);
      lvl <= 1'b1;
      repeat (7 * f - 2) @(posedge mclk);
      lvl <= 1'b0;
      repeat (40) @(posedge mclk);
      rck(cfg);
      lvl <= 1'b1;
      repeat (40) @(posedge mclk);
      rck(cfg | 8'h02);
      lvl <= 1'b0;
      repeat (40) @(posedge mclk);
    end
  endtask
  task automatic t_stop();
    wc(8'hEF);
    stop_recover <= 1'b1;
    @(posedge mclk);
    stop_recover <= 1'b0;
    rck(8'h20);
    rstn <= 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rck(8'h00);
    s_axi_wstrb <= 4'hE;
    wc(8'hFF);
    rck(8'h00);
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    results();
  end
  initial begin
    rstn = 1'b0;
    stop_recover = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    short_timer_output = 1'b0;
    long_timer_output = 1'b0;
    port_out_data = 1'b0;
    port_out_oe_n = 1'b1;
    src = 1'b0;
    lvl = 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_tx();
    t_demod();
    t_filter();
    t_stop();
    results();
  end
endmodule // dual_timer_shared_control_tb
`default_nettype wire
